/* File: rtl/asr_receiver.sv */
/*
 * Asynchronous serial receiver with a two-entry receive FIFO, AXI4-Lite
 * registers and one level interrupt output.
 * Assumes rx_pin is asynchronous to clk and idles high; the AXI master
 * keeps one write and one read outstanding at most.
 */
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
// Notes on behaviour
// - In idle, only a falling edge on the line starts a character.
// - Wait half a bit, then check the start bit is still low.
// - High at start midpoint: abandon silently and watch for a new edge.
// - Step one bit period per bit, majority vote, shift into shift register.
// - Repeat bit sampling until the configured eight or nine bits are in.
// - One bit later sample stop; a low stop marks a framing error.
// - Completed character enters the FIFO and pending flag rises.
// - Reading the data register returns and removes the oldest character.
// - While overrun is set, no new character is accepted.
// - Pending is high when enabled and the FIFO holds a character.
// - Pending is read-only; it follows FIFO occupancy and the receive enable.
// - Interrupt needs peripheral and global enables plus pending with receive enable, or an unmasked overrun or framing flag.
// - Pending reflects occupancy whatever the interrupt enables are.
// - Bit recovery runs on a sixteen-times baud tick; shift once per bit.
// - The FIFO holds two complete characters.
// - Frame: low start, eight or nine data bits LSB first, high stop.
// - First data bit received lands in bit zero.
module asr_receiver (
	input wire logic clk, // System clock
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic rx_pin, // Serial receive line
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	output logic irq // Level interrupt
);
	// =====================================================================
	// State
	typedef struct packed {
		asr_pkg::asr_bus_type bus;
		asr_pkg::asr_line_type ln;
		logic rx_enable;
		logic nine_bits;
		logic [15:0] divisor;
		logic rx_irq_enable;
		logic ovr_mask;
		logic fe_mask;
		logic periph_irq_enable;
		logic global_irq_enable;
		logic overrun;
		logic fe_event;
		logic [1:0][9:0] fifo;
		logic [1:0] count;
		logic rd_ptr;
	} asr_state_type;

	asr_state_type st;
	asr_state_type next_st;
	logic tick;
	logic decide;
	logic vote;
	logic fall;
	logic rx_pending_flag;
	logic ar_hs;
	logic pop;
	logic push_try;
	logic push;
	logic do_write;
	logic [9:0] char_word;
	logic [31:0] rd_word;
	logic [1:0] rd_resp;

	// =====================================================================
	// Combinational helpers
	// Oversampling tick at divisor+1 clocks, sixteen per bit
	assign tick = (st.ln.bcnt >= st.divisor);
	assign decide = tick && (st.ln.sub == asr_pkg::VOTE_LAST);
	// Two of three samples win
	assign vote = (st.ln.votes[0] & st.ln.votes[1]) | (st.ln.votes[0] & st.ln.rx_sync)
		| (st.ln.votes[1] & st.ln.rx_sync);
	assign fall = st.ln.rx_prev && !st.ln.rx_sync;
	assign rx_pending_flag = st.rx_enable && (st.count != 2'h0);
	assign ar_hs = s_axi_arvalid && !st.bus.rvalid;
	assign pop = ar_hs && (s_axi_araddr == asr_pkg::OFF_DATA) && (st.count != 2'h0);
	assign push_try = (st.ln.rx_state == asr_pkg::RX_STOP) && decide;
	// Overrun blocks all further characters; full FIFO without a pop drops it
	assign push = push_try && !st.overrun
		&& ((st.count != asr_pkg::FIFO_DEPTH) || pop);
	assign do_write = st.bus.aw_full && st.bus.w_full && !st.bus.bvalid;
	// Eight-bit characters sit in the top of the shift register
	assign char_word = {!vote, st.nine_bits ? st.ln.rx_shift_reg
		: {1'b0, st.ln.rx_shift_reg[8:1]}};

	// Handshake outputs
	assign s_axi_awready = !st.bus.aw_full;
	assign s_axi_wready = !st.bus.w_full;
	assign s_axi_arready = !st.bus.rvalid;
	assign s_axi_bvalid = st.bus.bvalid;
	assign s_axi_bresp = st.bus.bresp;
	assign s_axi_rvalid = st.bus.rvalid;
	assign s_axi_rdata = st.bus.rdata;
	assign s_axi_rresp = st.bus.rresp;
	// Global and peripheral enables and one enabled or unmasked source
	assign irq = st.global_irq_enable && st.periph_irq_enable
		&& ((st.rx_irq_enable && rx_pending_flag) || (st.ovr_mask && st.overrun)
		|| (st.fe_mask && st.fe_event));

	// Read multiplexer
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_resp = asr_pkg::RESP_OKAY;
		case (s_axi_araddr)
			asr_pkg::OFF_CTRL: begin
				rd_word[asr_pkg::CTRL_EN] = st.rx_enable;
				rd_word[asr_pkg::CTRL_NINE] = st.nine_bits;
			end
			asr_pkg::OFF_BAUD: rd_word[15:0] = st.divisor;
			asr_pkg::OFF_DATA: begin
				if (st.count != 2'h0) begin
					rd_word[9:0] = st.fifo[st.rd_ptr];
				end
			end
			asr_pkg::OFF_FLAG: begin
				rd_word[asr_pkg::FLAG_PEND] = rx_pending_flag;
				rd_word[asr_pkg::FLAG_OVR] = st.overrun;
				rd_word[asr_pkg::FLAG_FE] = st.fe_event;
				rd_word[asr_pkg::FLAG_CNT +: 2] = st.count;
			end
			asr_pkg::OFF_IEN: begin
				rd_word[asr_pkg::IEN_RX] = st.rx_irq_enable;
				rd_word[asr_pkg::FLAG_OVR] = st.ovr_mask;
				rd_word[asr_pkg::FLAG_FE] = st.fe_mask;
			end
			asr_pkg::OFF_ICTL: begin
				rd_word[asr_pkg::ICTL_PERIPH] = st.periph_irq_enable;
				rd_word[asr_pkg::ICTL_GLOBAL] = st.global_irq_enable;
			end
			default: rd_resp = asr_pkg::RESP_SLVERR;
		endcase
	end

	// =====================================================================
	// Next state
	always_comb begin
		next_st = st;
		// Line synchroniser and edge memory
		next_st.ln.rx_meta = rx_pin;
		next_st.ln.rx_sync = st.ln.rx_meta;
		next_st.ln.rx_prev = st.ln.rx_sync;
		next_st.ln.bcnt = tick ? 16'h0000 : st.ln.bcnt + 16'h0001;
		if (tick) begin
			next_st.ln.sub = st.ln.sub + 4'h1;
			if (st.ln.sub == asr_pkg::VOTE_FIRST) begin
				next_st.ln.votes[0] = st.ln.rx_sync;
			end
			if (st.ln.sub == asr_pkg::VOTE_FIRST + 4'h1) begin
				next_st.ln.votes[1] = st.ln.rx_sync;
			end
		end
		// Bit recovery
		case (st.ln.rx_state)
			asr_pkg::RX_IDLE: begin
				if (st.rx_enable && fall) begin
					next_st.ln.rx_state = asr_pkg::RX_START;
					next_st.ln.bcnt = 16'h0000;
					next_st.ln.sub = 4'h0;
					next_st.ln.bitcnt = 4'h0;
				end
			end
			asr_pkg::RX_START: begin
				if (decide) begin
					next_st.ln.rx_state = vote ? asr_pkg::RX_IDLE : asr_pkg::RX_DATA;
				end
			end
			asr_pkg::RX_DATA: begin
				if (decide) begin
					next_st.ln.rx_shift_reg = {vote, st.ln.rx_shift_reg[8:1]};
					next_st.ln.bitcnt = st.ln.bitcnt + 4'h1;
					if (st.ln.bitcnt + 4'h1 >= (st.nine_bits ? asr_pkg::BITS_NINE
						: asr_pkg::BITS_EIGHT)) begin
						next_st.ln.rx_state = asr_pkg::RX_STOP;
					end
				end
			end
			asr_pkg::RX_STOP: begin
				if (decide) begin
					next_st.ln.rx_state = asr_pkg::RX_IDLE;
				end
			end
			default: next_st.ln.rx_state = asr_pkg::RX_IDLE;
		endcase
		if (!st.rx_enable) begin
			next_st.ln.rx_state = asr_pkg::RX_IDLE;
		end

		// FIFO pop on data read, push on completed character
		if (pop) begin
			next_st.rd_ptr = !st.rd_ptr;
		end
		if (push) begin
			next_st.fifo[st.rd_ptr ^ st.count[0]] = char_word;
		end
		next_st.count = st.count + {1'b0, push} - {1'b0, pop};

		// Bus write channel
		if (s_axi_awvalid && !st.bus.aw_full) begin
			next_st.bus.aw_full = 1'b1;
			next_st.bus.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st.bus.w_full) begin
			next_st.bus.w_full = 1'b1;
			next_st.bus.w_data = s_axi_wdata;
			next_st.bus.w_strb = s_axi_wstrb;
		end
		if (st.bus.bvalid && s_axi_bready) begin
			next_st.bus.bvalid = 1'b0;
		end
		if (do_write) begin
			next_st.bus.aw_full = 1'b0;
			next_st.bus.w_full = 1'b0;
			next_st.bus.bvalid = 1'b1;
			next_st.bus.bresp = asr_pkg::RESP_OKAY;
			case (st.bus.aw_addr)
				asr_pkg::OFF_CTRL: begin
					if (st.bus.w_strb[0]) begin
						next_st.rx_enable = st.bus.w_data[asr_pkg::CTRL_EN];
						next_st.nine_bits = st.bus.w_data[asr_pkg::CTRL_NINE];
					end
				end
				asr_pkg::OFF_BAUD: begin
					if (st.bus.w_strb[0]) begin
						next_st.divisor[7:0] = st.bus.w_data[7:0];
					end
					if (st.bus.w_strb[1]) begin
						next_st.divisor[15:8] = st.bus.w_data[15:8];
					end
				end
				asr_pkg::OFF_DATA: ;
				asr_pkg::OFF_FLAG: begin
					// Pending and count bits ignore writes; overrun and framing clear on a one
					if (st.bus.w_strb[0]) begin
						if (st.bus.w_data[asr_pkg::FLAG_OVR]) begin
							next_st.overrun = 1'b0;
						end
						if (st.bus.w_data[asr_pkg::FLAG_FE]) begin
							next_st.fe_event = 1'b0;
						end
					end
				end
				asr_pkg::OFF_IEN: begin
					if (st.bus.w_strb[0]) begin
						next_st.rx_irq_enable = st.bus.w_data[asr_pkg::IEN_RX];
						next_st.ovr_mask = st.bus.w_data[asr_pkg::FLAG_OVR];
						next_st.fe_mask = st.bus.w_data[asr_pkg::FLAG_FE];
					end
				end
				asr_pkg::OFF_ICTL: begin
					if (st.bus.w_strb[0]) begin
						next_st.periph_irq_enable = st.bus.w_data[asr_pkg::ICTL_PERIPH];
						next_st.global_irq_enable = st.bus.w_data[asr_pkg::ICTL_GLOBAL];
					end
				end
				default: next_st.bus.bresp = asr_pkg::RESP_SLVERR;
			endcase
		end
		// Hardware events set after the clear so the set wins
		if (push_try && !push) begin
			next_st.overrun = 1'b1;
		end
		if (push && !vote) begin
			next_st.fe_event = 1'b1;
		end

		// Bus read channel
		if (st.bus.rvalid && s_axi_rready) begin
			next_st.bus.rvalid = 1'b0;
		end
		if (ar_hs) begin
			next_st.bus.rvalid = 1'b1;
			next_st.bus.rdata = rd_word;
			next_st.bus.rresp = rd_resp;
		end
	end

	// Register the whole state
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
			st.ln.rx_meta <= 1'b1;
			st.ln.rx_sync <= 1'b1;
			st.ln.rx_prev <= 1'b1;
			st.divisor <= asr_pkg::BAUD_RESET;
		end else begin
			st <= next_st;
		end
	end

	// =====================================================================
	// Checks
	sequence s_stop_decide;
		st.ln.rx_state == asr_pkg::RX_STOP && decide;
	endsequence
	sequence s_data_read;
		ar_hs && s_axi_araddr == asr_pkg::OFF_DATA;
	endsequence

	property p_idle_wait;
		@(posedge clk) disable iff (sys_rst)
		st.ln.rx_state == asr_pkg::RX_IDLE && !(st.rx_enable && fall)
		|=> st.ln.rx_state == asr_pkg::RX_IDLE;
	endproperty
	a_idle_wait: assert property (p_idle_wait) else $error("left idle without edge");

	property p_start_check;
		@(posedge clk) disable iff (sys_rst)
		st.ln.rx_state == asr_pkg::RX_START && decide && st.rx_enable
		|=> st.ln.rx_state == ($past(vote) ? asr_pkg::RX_IDLE : asr_pkg::RX_DATA);
	endproperty
	a_start_check: assert property (p_start_check) else $error("start check wrong");

	property p_stop_push;
		@(posedge clk) disable iff (sys_rst)
		s_stop_decide ##0 (!st.overrun && st.count == 2'h0 && !pop)
		|=> st.count == 2'h1 && st.fifo[st.rd_ptr][asr_pkg::DATA_FE] == !$past(vote);
	endproperty
	a_stop_push: assert property (p_stop_push) else $error("character not stored");

	property p_overrun_set;
		@(posedge clk) disable iff (sys_rst)
		s_stop_decide ##0 (st.count == asr_pkg::FIFO_DEPTH && !pop)
		|=> st.overrun && st.count == asr_pkg::FIFO_DEPTH;
	endproperty
	a_overrun_set: assert property (p_overrun_set) else $error("overrun missed");

	property p_overrun_block;
		@(posedge clk) disable iff (sys_rst)
		s_stop_decide ##0 st.overrun |=> st.count == $past(st.count) - {1'b0, $past(pop)};
	endproperty
	a_overrun_block: assert property (p_overrun_block) else $error("accepted in overrun");

	property p_read_pop;
		@(posedge clk) disable iff (sys_rst)
		s_data_read ##0 (st.count != 2'h0 && !push)
		|=> st.count == $past(st.count) - 2'h1 && s_axi_rvalid;
	endproperty
	a_read_pop: assert property (p_read_pop) else $error("read did not pop");

	property p_pending;
		@(posedge clk) disable iff (sys_rst)
		st.count == 2'h0 || !st.rx_enable |-> !irq || !st.rx_irq_enable || st.overrun
		|| st.fe_event;
	endproperty
	a_pending: assert property (p_pending) else $error("pending without character");

	property p_irq_gate;
		@(posedge clk) disable iff (sys_rst)
		irq |-> st.global_irq_enable && st.periph_irq_enable;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated");

	property p_bit_limit;
		@(posedge clk) disable iff (sys_rst)
		st.ln.rx_state == asr_pkg::RX_DATA |-> st.ln.bitcnt < asr_pkg::BITS_NINE;
	endproperty
	a_bit_limit: assert property (p_bit_limit) else $error("too many data bits");

	property p_tick_step;
		@(posedge clk) disable iff (sys_rst)
		st.ln.rx_state != asr_pkg::RX_IDLE && !tick |=> st.ln.sub == $past(st.ln.sub);
	endproperty
	a_tick_step: assert property (p_tick_step) else $error("sub-bit moved off tick");
endmodule

/* File: rtl/asr_pkg.sv */
/*
 * Shared constants and types of the asynchronous serial receiver.
 * Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package asr_pkg;
	// =====================================================================
	// Register map (byte addresses)
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_BAUD = 8'h04;
	localparam logic [7:0] OFF_DATA = 8'h08;
	localparam logic [7:0] OFF_FLAG = 8'h0c;
	localparam logic [7:0] OFF_IEN = 8'h10;
	localparam logic [7:0] OFF_ICTL = 8'h14;

	// =====================================================================
	// Field positions
	localparam int CTRL_EN = 0;
	localparam int CTRL_NINE = 1;
	localparam int FLAG_PEND = 0;
	localparam int FLAG_OVR = 1;
	localparam int FLAG_FE = 2;
	localparam int FLAG_CNT = 4;
	localparam int IEN_RX = 0;
	localparam int ICTL_PERIPH = 0;
	localparam int ICTL_GLOBAL = 1;
	localparam int DATA_FE = 9;

	// =====================================================================
	// Reset values, bus answers and timing
	localparam logic [15:0] BAUD_RESET = 16'h0001;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [3:0] VOTE_FIRST = 4'h7;
	localparam logic [3:0] VOTE_LAST = 4'h9;
	localparam logic [3:0] BITS_EIGHT = 4'h8;
	localparam logic [3:0] BITS_NINE = 4'h9;
	localparam logic [1:0] FIFO_DEPTH = 2'h2;

	// =====================================================================
	// Types
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asr_rx_state_type;

	typedef struct packed {
		logic aw_full;
		logic [7:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} asr_bus_type;

	typedef struct packed {
		logic rx_meta;
		logic rx_sync;
		logic rx_prev;
		asr_rx_state_type rx_state;
		logic [15:0] bcnt;
		logic [3:0] sub;
		logic [3:0] bitcnt;
		logic [1:0] votes;
		logic [8:0] rx_shift_reg;
	} asr_line_type;
endpackage

/* File: testbench/asr_tx_model.sv */
/*
 * Remote serial transmitter that drives the receive line of the receiver.
 * Assumes the bench calls its tasks just after a rising clock edge.
 */
module asr_tx_model (
	input wire logic clk, // Clock that times the bits
	output logic line // Serial line, idles high
);
	timeunit 1ns;
	timeprecision 1ps;
	int bit_clks = 32; // Clocks per bit, set by the bench

	// ==========
	// Line driving
	initial line = 1'b1;

	// Drive one level for a number of clocks
	task automatic hold(input logic v, input int n);
		line <= v;
		repeat (n) @(posedge clk);
	endtask

	// One frame; spike flips the first data bit for two clocks at its centre
	task automatic send(input logic [8:0] d, input int nbits, input logic stop,
		input logic spike);
		@(posedge clk);
		hold(1'b0, bit_clks); // Start bit low
		for (int i = 0; i < nbits; i++) begin
			if (i == 0 && spike) begin
				hold(d[0], bit_clks / 2 - 1);
				hold(!d[0], 2);
				hold(d[0], bit_clks / 2 - 1);
			end else begin
				hold(d[i], bit_clks); // Data, low bit first
			end
		end
		hold(stop, bit_clks); // Stop bit, high unless told otherwise
		hold(1'b1, bit_clks); // Idle mark before the next frame
	endtask

	// Low pulse shorter than half a bit, then idle
	task automatic glitch(input int n);
		@(posedge clk);
		hold(1'b0, n);
		hold(1'b1, 3 * bit_clks);
	endtask
endmodule

/* File: testbench/tb_asr_receiver.sv */
/*
 * Self-checking bench of the serial receiver: register tasks on AXI4-Lite,
 * frames from the transmitter model, expected values from the register map.
 * Assumes baud divisor reset value 1, so one bit lasts 32 clocks.
 */
`define ASR_CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
	$display("wrong value %s expected %h seen %h", nm, exp, got); end end

module tb_asr_receiver;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic rx_pin;
	logic [7:0] s_axi_awaddr = '0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = '0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = '0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic irq;
	int bad_count = 0;
	int tests_run = 0;
	logic [31:0] rd;
	logic [1:0] resp;

	// Clock of 4 ns
	always #2 clk = ~clk;

	asr_receiver i_asr_receiver (.clk(clk), .sys_rst(sys_rst), .rx_pin(rx_pin),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

	asr_tx_model i_asr_tx_model (.clk(clk), .line(rx_pin));

	// ==========
	// Closing report
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ==========
	// Bus tasks
	// Write: address and data offered together, each released when taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_done;
		logic w_done;
		int n;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (aw_done && w_done && s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
			if (!aw_done && s_axi_awready) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		if (n == 100) begin
			bad_count++;
			final_report();
		end
	endtask

	// Read: address held until taken, rready held until data arrives
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_done;
		int n;
		ar_done = 1'b0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (ar_done && s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
			if (!ar_done && s_axi_arready) begin
				ar_done = 1'b1;
				s_axi_arvalid <= 1'b0;
			end
		end
		if (n == 100) begin
			bad_count++;
			final_report();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_write(a, d, r);
		`ASR_CHK("write response", asr_pkg::RESP_OKAY, r)
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
		logic [31:0] d;
		logic [1:0] r;
		axi_read(a, d, r);
		`ASR_CHK(nm, e, d)
		`ASR_CHK("read response", asr_pkg::RESP_OKAY, r)
	endtask

	// Expected flag register word
	function automatic logic [31:0] flagv(input logic p, input logic o, input logic f,
		input logic [1:0] c);
		flagv = '0;
		flagv[asr_pkg::FLAG_PEND] = p;
		flagv[asr_pkg::FLAG_OVR] = o;
		flagv[asr_pkg::FLAG_FE] = f;
		flagv[asr_pkg::FLAG_CNT +: 2] = c;
	endfunction

	// ==========
	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		`ASR_CHK("irq after reset", 1'b0, irq)
		rd_chk(asr_pkg::OFF_CTRL, 32'h0, "ctrl reset");
		rd_chk(asr_pkg::OFF_BAUD, {16'h0, asr_pkg::BAUD_RESET}, "baud reset");
		rd_chk(asr_pkg::OFF_FLAG, flagv(0, 0, 0, 0), "flag reset");
		axi_read(8'h40, rd, resp);
		`ASR_CHK("unmapped read", asr_pkg::RESP_SLVERR, resp)
		axi_write(8'h40, 32'h1, resp);
		`ASR_CHK("unmapped write", asr_pkg::RESP_SLVERR, resp)
		wr(asr_pkg::OFF_CTRL, 32'h1);
		i_asr_tx_model.glitch(8);
		rd_chk(asr_pkg::OFF_FLAG, flagv(0, 0, 0, 0), "flag after glitch"); // Abort
		i_asr_tx_model.send(9'h0a5, 8, 1'b1, 1'b0);
		rd_chk(asr_pkg::OFF_FLAG, flagv(1, 0, 0, 1), "flag one char"); // Push
		rd_chk(asr_pkg::OFF_DATA, 32'h0a5, "char order"); // Bit zero first
		rd_chk(asr_pkg::OFF_FLAG, flagv(0, 0, 0, 0), "flag after pop"); // Pop
		wr(asr_pkg::OFF_CTRL, 32'h3);
		i_asr_tx_model.send(9'h1c3, 9, 1'b1, 1'b0);
		rd_chk(asr_pkg::OFF_DATA, 32'h1c3, "nine bit char"); // Length
		wr(asr_pkg::OFF_CTRL, 32'h1);
		i_asr_tx_model.send(9'h055, 8, 1'b0, 1'b0);
		rd_chk(asr_pkg::OFF_DATA, 32'h255, "char framing bit"); // Low stop
		rd_chk(asr_pkg::OFF_FLAG, flagv(0, 0, 1, 0), "framing event"); // Event
		// Framing source alone raises the interrupt through its mask
		wr(asr_pkg::OFF_IEN, 32'h4);
		wr(asr_pkg::OFF_ICTL, 32'h3);
		rd_chk(asr_pkg::OFF_IEN, 32'h4, "enable readback");
		`ASR_CHK("irq framing source", 1'b1, irq) // Masked source
		wr(asr_pkg::OFF_FLAG, flagv(1, 0, 1, 0));
		`ASR_CHK("irq after event clear", 1'b0, irq) // Cleared source
		rd_chk(asr_pkg::OFF_FLAG, flagv(0, 0, 0, 0), "pending write"); // Read-only
		for (int i = 1; i <= 4; i++) begin
			i_asr_tx_model.send({1'b0, i[3:0], i[3:0]}, 8, 1'b1, 1'b0);
		end
		rd_chk(asr_pkg::OFF_FLAG, flagv(1, 1, 0, 2), "full and overrun"); // Drop
		rd_chk(asr_pkg::OFF_DATA, 32'h011, "oldest first"); // High stop clears
		i_asr_tx_model.send(9'h066, 8, 1'b1, 1'b0);
		rd_chk(asr_pkg::OFF_FLAG, flagv(1, 1, 0, 1), "intake in overrun"); // Blocked
		rd_chk(asr_pkg::OFF_DATA, 32'h022, "second char"); // Two held
		wr(asr_pkg::OFF_FLAG, flagv(0, 1, 0, 0));
		i_asr_tx_model.send(9'h077, 8, 1'b1, 1'b0);
		rd_chk(asr_pkg::OFF_FLAG, flagv(1, 0, 0, 1), "intake resumed"); // Cleared
		for (int k = 0; k < 8; k++) begin
			wr(asr_pkg::OFF_IEN, {31'h0, k[0]});
			wr(asr_pkg::OFF_ICTL, {30'h0, k[2:1]});
			`ASR_CHK("irq enables", logic'(k == 7), irq) // All three
			rd_chk(asr_pkg::OFF_FLAG, flagv(1, 0, 0, 1), "pending"); // Polled
		end
		rd_chk(asr_pkg::OFF_DATA, 32'h077, "char before irq clear");
		`ASR_CHK("irq after pop", 1'b0, irq) // Empty
		i_asr_tx_model.send(9'h05a, 8, 1'b1, 1'b0);
		`ASR_CHK("irq with char", 1'b1, irq) // Raised
		wr(asr_pkg::OFF_CTRL, 32'h0);
		rd_chk(asr_pkg::OFF_FLAG, flagv(0, 0, 0, 1), "pending disabled"); // Off
		`ASR_CHK("irq disabled", 1'b0, irq) // Off
		wr(asr_pkg::OFF_CTRL, 32'h1);
		rd_chk(asr_pkg::OFF_DATA, 32'h05a, "kept char"); // Kept
		wr(asr_pkg::OFF_BAUD, 32'h3);
		i_asr_tx_model.bit_clks = 64;
		i_asr_tx_model.send(9'h0c6, 8, 1'b1, 1'b1);
		rd_chk(asr_pkg::OFF_DATA, 32'h0c6, "slow char with spike"); // Vote
		final_report();
	end
endmodule
